/* File: pkg/roc_pkg.sv */
// Behaviour
// - control bit 7 enables oscillator automatic gain control; resets to 0.
// - control bit 6 picks the mode: 0 self-oscillate, 1 crystal.
// - control bit 5 turns the bias doubling on (1) or off (0).
// - control bit 4 is read-only and shows 1 when amplitude suffices.
// - control bits 3:0 read zero and ignore writes.
// - load config bit 7 enables load capacitance stepping; resets to 0.
// - load config bit 6 is read-only, set once applied code equals target.
// - the ready bit reads 0 while the applied code is still stepping.
// - load config bits 5:4 read zero and ignore writes.
// - load config bits 3:0 hold the target load capacitance code.
// - writing 0xE7 to the pin register shorts the two crystal pins.
// - writing 0x67 to the pin register removes the short.
// - the three registers sit at indexes 0x05, 0x06 and 0x07.
package roc_pkg;

    // ****************************************
    // register map: index, byte address is index times four
    // ****************************************
    localparam logic [7:0] IDX_CTRL = 8'h05;
    localparam logic [7:0] IDX_LOAD = 8'h06;
    localparam logic [7:0] IDX_PIN = 8'h07;
    localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};
    localparam logic [7:0] ADDR_LOAD = {IDX_LOAD[5:0], 2'b00};
    localparam logic [7:0] ADDR_PIN = {IDX_PIN[5:0], 2'b00};

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int CTRL_GAIN_BIT = 7;
    localparam int CTRL_MODE_BIT = 6;
    localparam int CTRL_BIAS_BIT = 5;
    localparam int CTRL_VALID_BIT = 4;
    localparam int LOAD_STEP_BIT = 7;
    localparam int LOAD_READY_BIT = 6;
    localparam int CAP_W = 4;
    localparam logic [CAP_W-1:0] CAP_TARGET_RST = 4'h0;
    localparam logic [7:0] PIN_SHORT_CODE = 8'hE7;
    localparam logic [7:0] PIN_OPEN_CODE = 8'h67;
    localparam logic [7:0] PIN_RST = 8'h67;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLOCK_PERIOD_NS = 5;
    localparam int STEP_TIME_NS = 1000;
    localparam int STEP_CYCLES = STEP_TIME_NS / CLOCK_PERIOD_NS;
    localparam int TICK_W = 8;
    localparam logic [TICK_W-1:0] STEP_LAST = TICK_W'(STEP_CYCLES - 1);

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } roc_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } roc_apb_rsp_t;

    typedef struct packed {
        logic gain_control_enable;
        logic crystal_mode_select;
        logic bias_double_enable;
        logic crystal_short;
        logic cap_ready;
        logic [3:0] cap_applied;
    } roc_osc_out_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RESP = 2'b10
    } roc_bus_state_t;

endpackage

/* File: logic/roc_cap_stepper.sv */
module roc_cap_stepper
    import roc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cap_step_enable,
    input wire logic [CAP_W-1:0] cap_target_code,
    output logic [CAP_W-1:0] cap_applied,
    output logic cap_ready
);

    typedef struct packed {
        logic [TICK_W-1:0] tick;
        logic [CAP_W-1:0] applied;
        logic ready;
    } roc_step_state_t;

    roc_step_state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = (s_q.tick == STEP_LAST) ? '0 : TICK_W'(s_q.tick + 1'b1);
        if (!cap_step_enable) begin
            s_d.applied = cap_target_code;
        end else if (s_q.tick == STEP_LAST) begin
            // one code per step period keeps the oscillator from losing lock
            if (s_q.applied < cap_target_code) begin
                s_d.applied = CAP_W'(s_q.applied + 1'b1);
            end else if (s_q.applied > cap_target_code) begin
                s_d.applied = CAP_W'(s_q.applied - 1'b1);
            end
        end
        s_d.ready = (s_d.applied == cap_target_code);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{tick: '0, applied: CAP_TARGET_RST, ready: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign cap_applied = s_q.applied;
    assign cap_ready = s_q.ready;

    a_step_single: assert property (@(posedge clock) disable iff (!rst_n)
        cap_step_enable |=> (s_q.applied == $past(s_q.applied))
            || (s_q.applied == CAP_W'($past(s_q.applied) + 1'b1))
            || (s_q.applied == CAP_W'($past(s_q.applied) - 1'b1)))
        else $error("applied code moved more than one step");

    a_step_direct: assert property (@(posedge clock) disable iff (!rst_n)
        !cap_step_enable |=> s_q.applied == $past(cap_target_code) && s_q.ready)
        else $error("applied code not taken directly when stepping is off");

endmodule // roc_cap_stepper

/* File: logic/roc_pin_short.sv */
module roc_pin_short
    import roc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic crystal_short
);

    typedef struct packed {
        logic shorted;
    } roc_pin_state_t;

    roc_pin_state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (wr_en && wr_data == PIN_SHORT_CODE) begin
            s_d.shorted = 1'b1;
        end else if (wr_en && wr_data == PIN_OPEN_CODE) begin
            s_d.shorted = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{shorted: (PIN_RST == PIN_SHORT_CODE)};
        end else begin
            s_q <= s_d;
        end
    end

    assign crystal_short = s_q.shorted;

    a_short_holds: assert property (@(posedge clock) disable iff (!rst_n)
        !(wr_en && (wr_data == PIN_SHORT_CODE || wr_data == PIN_OPEN_CODE))
            |=> $stable(s_q.shorted))
        else $error("pin short changed without a recognised code");

    a_short_codes: assert property (@(posedge clock) disable iff (!rst_n)
        wr_en |=> s_q.shorted == ($past(wr_data) == PIN_SHORT_CODE) || $stable(s_q.shorted))
        else $error("pin short does not follow the written code");

endmodule // roc_pin_short

/* File: logic/roc_osc_regs.sv */
// Design decision made here: the APB interface to the registers.
module roc_osc_regs
    import roc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire roc_apb_req_t apb_req,
    output roc_apb_rsp_t apb_rsp,
    input wire logic amp_detect,
    output roc_osc_out_t osc_out
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        roc_bus_state_t bus;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic gain_control_enable;
        logic crystal_mode_select;
        logic bias_double_enable;
        logic amplitude_valid;
        logic cap_step_enable;
        logic [CAP_W-1:0] cap_target_code;
    } roc_main_state_t;

    localparam roc_main_state_t MAIN_RST = '{
        bus: BUS_IDLE,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0000_0000,
        gain_control_enable: 1'b0,
        crystal_mode_select: 1'b0,
        bias_double_enable: 1'b0,
        amplitude_valid: 1'b0,
        cap_step_enable: 1'b0,
        cap_target_code: CAP_TARGET_RST
    };

    roc_main_state_t s_q, s_d;

    logic hit_ctrl;
    logic hit_load;
    logic hit_pin;
    logic hit_any;
    logic commit;
    logic wr_commit;
    logic pin_wr;
    logic [7:0] rd_byte;
    logic [CAP_W-1:0] cap_applied;
    logic cap_ready;
    logic crystal_short;

    // ****************************************
    // address decode
    // ****************************************
    always_comb begin
        hit_ctrl = 1'b0;
        hit_load = 1'b0;
        hit_pin = 1'b0;
        if (apb_req.paddr == ADDR_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (apb_req.paddr == ADDR_LOAD) begin
            hit_load = 1'b1;
        end else if (apb_req.paddr == ADDR_PIN) begin
            hit_pin = 1'b1;
        end
    end

    assign hit_any = hit_ctrl | hit_load | hit_pin;
    // the master holds its request until it sees pready, so commit there
    assign commit = (s_q.bus == BUS_RESP) && apb_req.psel && apb_req.penable;
    assign wr_commit = commit && apb_req.pwrite;
    assign pin_wr = wr_commit && hit_pin;

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        rd_byte = 8'h00;
        if (hit_ctrl) begin
            // low nibble stays zero
            rd_byte[CTRL_GAIN_BIT] = s_q.gain_control_enable;
            rd_byte[CTRL_MODE_BIT] = s_q.crystal_mode_select;
            rd_byte[CTRL_BIAS_BIT] = s_q.bias_double_enable;
            rd_byte[CTRL_VALID_BIT] = s_q.amplitude_valid;
        end else if (hit_load) begin
            // bits 5:4 stay zero
            rd_byte[LOAD_STEP_BIT] = s_q.cap_step_enable;
            rd_byte[LOAD_READY_BIT] = cap_ready;
            rd_byte[CAP_W-1:0] = s_q.cap_target_code;
        end
        // the pin register is write only and reads zero
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.amplitude_valid = amp_detect;
        case (s_q.bus)
            BUS_IDLE: begin
                s_d.pready = 1'b0;
                s_d.pslverr = 1'b0;
                if (apb_req.psel && apb_req.penable) begin
                    // one wait state; read data is captured with pready
                    s_d.bus = BUS_RESP;
                    s_d.pready = 1'b1;
                    s_d.pslverr = !hit_any;
                    s_d.prdata = apb_req.pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
                end
            end
            BUS_RESP: begin
                s_d.bus = BUS_IDLE;
                s_d.pready = 1'b0;
                s_d.pslverr = 1'b0;
            end
            default: begin
                s_d.bus = BUS_IDLE;
                s_d.pready = 1'b0;
                s_d.pslverr = 1'b0;
            end
        endcase
        if (wr_commit && hit_ctrl) begin
            // bit 4 and the low nibble are not writable
            s_d.gain_control_enable = apb_req.pwdata[CTRL_GAIN_BIT];
            s_d.crystal_mode_select = apb_req.pwdata[CTRL_MODE_BIT];
            s_d.bias_double_enable = apb_req.pwdata[CTRL_BIAS_BIT];
        end
        if (wr_commit && hit_load) begin
            s_d.cap_step_enable = apb_req.pwdata[LOAD_STEP_BIT];
            s_d.cap_target_code = apb_req.pwdata[CAP_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= MAIN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // sub blocks
    // ****************************************
    roc_cap_stepper u_stepper (
        .clock(clock),
        .rst_n(rst_n),
        .cap_step_enable(s_q.cap_step_enable),
        .cap_target_code(s_q.cap_target_code),
        .cap_applied(cap_applied),
        .cap_ready(cap_ready)
    );

    roc_pin_short u_pin (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(pin_wr),
        .wr_data(apb_req.pwdata[7:0]),
        .crystal_short(crystal_short)
    );

    // ****************************************
    // outputs
    // ****************************************
    assign apb_rsp.pready = s_q.pready;
    assign apb_rsp.pslverr = s_q.pslverr;
    assign apb_rsp.prdata = s_q.prdata;
    assign osc_out.gain_control_enable = s_q.gain_control_enable;
    assign osc_out.crystal_mode_select = s_q.crystal_mode_select;
    assign osc_out.bias_double_enable = s_q.bias_double_enable;
    assign osc_out.crystal_short = crystal_short;
    assign osc_out.cap_ready = cap_ready;
    assign osc_out.cap_applied = cap_applied;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_access_start;
        s_q.bus == BUS_IDLE && apb_req.psel && apb_req.penable;
    endsequence

    sequence s_rd_ctrl;
        s_access_start and (hit_ctrl && !apb_req.pwrite);
    endsequence

    sequence s_rd_load;
        s_access_start and (hit_load && !apb_req.pwrite);
    endsequence

    a_apb_answer: assert property (
        s_access_start |=> apb_rsp.pready ##1 !apb_rsp.pready)
        else $error("apb answer not a single pulse one cycle after access");

    a_unmapped_err: assert property (
        s_access_start and !hit_any |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
        else $error("unmapped address not flagged");

    a_ctrl_low_zero: assert property (
        s_rd_ctrl |=> apb_rsp.prdata[3:0] == 4'h0 && apb_rsp.prdata[31:8] == 24'h00_0000)
        else $error("control low nibble not zero");

    a_valid_read: assert property (
        s_rd_ctrl |=> apb_rsp.prdata[CTRL_VALID_BIT] == $past(s_q.amplitude_valid))
        else $error("amplitude valid bit wrong on read");

    a_valid_follow: assert property (
        ##1 s_q.amplitude_valid == $past(amp_detect))
        else $error("amplitude valid not tracking detector");

    a_gain_write: assert property (
        wr_commit && hit_ctrl |=> osc_out.gain_control_enable == $past(apb_req.pwdata[7]))
        else $error("gain control enable not written");

    a_mode_write: assert property (
        wr_commit && hit_ctrl |=> osc_out.crystal_mode_select == $past(apb_req.pwdata[6]))
        else $error("crystal mode select not written");

    a_bias_write: assert property (
        wr_commit && hit_ctrl |=> osc_out.bias_double_enable == $past(apb_req.pwdata[5]))
        else $error("bias double enable not written");

    a_ctrl_hold: assert property (
        !(wr_commit && hit_ctrl) |=> $stable(osc_out.gain_control_enable)
            && $stable(osc_out.crystal_mode_select) && $stable(osc_out.bias_double_enable))
        else $error("control bits changed without a write");

    a_step_write: assert property (
        wr_commit && hit_load |=> s_q.cap_step_enable == $past(apb_req.pwdata[7])
            && s_q.cap_target_code == $past(apb_req.pwdata[3:0]))
        else $error("load config not written");

    a_load_mid_zero: assert property (
        s_rd_load |=> apb_rsp.prdata[5:4] == 2'b00)
        else $error("load config bits 5:4 not zero");

    a_ready_read: assert property (
        s_rd_load |=> apb_rsp.prdata[LOAD_READY_BIT] == $past(cap_ready)
            && apb_rsp.prdata[3:0] == $past(s_q.cap_target_code))
        else $error("load config read data wrong");

    a_ready_meaning: assert property (
        cap_ready == (cap_applied == s_q.cap_target_code) || $changed(s_q.cap_target_code))
        else $error("ready flag disagrees with applied code");

    a_pin_reads_zero: assert property (
        s_access_start and hit_pin and !apb_req.pwrite |=> apb_rsp.prdata == 32'h0000_0000)
        else $error("pin register not write only");

    a_pin_short_set: assert property (
        pin_wr && apb_req.pwdata[7:0] == PIN_SHORT_CODE |=> osc_out.crystal_short)
        else $error("short code did not short the pins");

    a_pin_short_clr: assert property (
        pin_wr && apb_req.pwdata[7:0] == PIN_OPEN_CODE |=> !osc_out.crystal_short)
        else $error("open code did not remove the short");

    // ****************************************
    // bus framing, hold and stepping checks
    // ****************************************
    sequence s_wr_pin_other;
        pin_wr && apb_req.pwdata[7:0] != PIN_SHORT_CODE
            && apb_req.pwdata[7:0] != PIN_OPEN_CODE;
    endsequence

    // ready compares against last cycle's target, so judge it only once the target sits still
    sequence s_target_steady;
        $stable(s_q.cap_target_code);
    endsequence

    a_err_with_ready: assert property (
        apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("error flag without ready");

    a_idle_no_ready: assert property (
        s_access_start |-> !apb_rsp.pready)
        else $error("access taken while an answer stands");

    a_commit_ready: assert property (
        commit |-> apb_rsp.pready)
        else $error("commit edge without ready");

    a_resp_returns: assert property (
        s_q.bus == BUS_RESP |=> s_q.bus == BUS_IDLE)
        else $error("bus did not return to idle after answer");

    a_bus_onehot: assert property (
        $onehot(s_q.bus))
        else $error("bus state not one-hot");

    a_wr_rdata_zero: assert property (
        s_access_start and apb_req.pwrite |=> apb_rsp.prdata == 32'h0000_0000)
        else $error("write answer carries read data");

    a_rdata_hold: assert property (
        !(s_q.bus == BUS_IDLE && apb_req.psel && apb_req.penable)
            |=> $stable(apb_rsp.prdata))
        else $error("read data changed without a new answer");

    a_upper_zero: assert property (
        apb_rsp.prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    a_unmapped_keep: assert property (
        wr_commit && !hit_any |=> $stable(s_q.cap_target_code)
            && $stable(osc_out.gain_control_enable) && $stable(osc_out.crystal_short))
        else $error("unmapped write changed a register");

    a_step_read: assert property (
        s_rd_load |=> apb_rsp.prdata[LOAD_STEP_BIT] == $past(s_q.cap_step_enable))
        else $error("step enable read back wrong");

    a_load_hold: assert property (
        !(wr_commit && hit_load) |=> $stable(s_q.cap_step_enable)
            && $stable(s_q.cap_target_code))
        else $error("load config changed without a write");

    a_ready_low: assert property (
        s_target_steady and (cap_applied != s_q.cap_target_code) |-> !cap_ready)
        else $error("ready set while still stepping");

    a_ready_high: assert property (
        s_target_steady and (cap_applied == s_q.cap_target_code) |-> cap_ready)
        else $error("ready clear although target reached");

    a_direct_apply: assert property (
        !s_q.cap_step_enable |=> cap_applied == $past(s_q.cap_target_code))
        else $error("target not applied directly");

    a_step_up: assert property (
        s_q.cap_step_enable && cap_applied < s_q.cap_target_code
            |=> cap_applied >= $past(cap_applied))
        else $error("applied code moved away from a higher target");

    a_step_down: assert property (
        s_q.cap_step_enable && cap_applied > s_q.cap_target_code
            |=> cap_applied <= $past(cap_applied))
        else $error("applied code moved away from a lower target");

    a_pin_other_keep: assert property (
        s_wr_pin_other |=> $stable(osc_out.crystal_short))
        else $error("unrecognised pin code changed the short");

    a_pin_idle_keep: assert property (
        !pin_wr |=> $stable(osc_out.crystal_short))
        else $error("pin short changed without a pin write");

endmodule // roc_osc_regs

/* File: bench/tb_roc_osc_regs.sv */
module tb_roc_osc_regs
    import roc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock;
    logic rst_n;
    roc_apb_req_t req;
    roc_apb_rsp_t rsp;
    logic amp_detect;
    roc_osc_out_t osc_out;
    int n_errors;
    int checks_done;

    roc_osc_regs roc_osc_regs_i (
        .clock(clock),
        .rst_n(rst_n),
        .apb_req(req),
        .apb_rsp(rsp),
        .amp_detect(amp_detect),
        .osc_out(osc_out)
    );

    // ****************************************
    // clock and common tasks
    // ****************************************
    always #2.5 clock = ~clock;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // the request stays put until pready is seen at a rising edge
    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                            output logic [31:0] rdata, output logic err);
        int i;
        @(posedge clock);
        req.psel <= 1'b1;
        req.pwrite <= wr;
        req.paddr <= addr;
        req.pwdata <= wdata;
        @(posedge clock);
        req.penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (rsp.pready === 1'b1) break;
        end
        if (i == 50) check(32'h0000_0bad, 32'h0000_0000);
        rdata = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b1, addr, {24'h00_0000, data}, rd, err);
        check({31'h0, err}, 32'h0000_0000);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b0, addr, 32'hffff_ffff, rd, err);
        check(rd, exp);
        check({31'h0, err}, 32'h0000_0000);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_values;
        rd_chk(ADDR_CTRL, 32'h0000_0000);
        rd_chk(ADDR_LOAD, 32'h0000_0040);
        rd_chk(ADDR_PIN, 32'h0000_0000);
        check({31'h0, osc_out.crystal_short}, 32'h0000_0000);
    endtask

    task automatic t_control;
        wr_reg(ADDR_CTRL, 8'hff);
        rd_chk(ADDR_CTRL, 32'h0000_00e0);
        check({29'h0, osc_out.gain_control_enable, osc_out.crystal_mode_select,
               osc_out.bias_double_enable}, 32'h0000_0007);
        wr_reg(ADDR_CTRL, 8'h4f);
        rd_chk(ADDR_CTRL, 32'h0000_0040);
        check({31'h0, osc_out.gain_control_enable}, 32'h0000_0000);
        check({31'h0, osc_out.crystal_mode_select}, 32'h0000_0001);
        check({31'h0, osc_out.bias_double_enable}, 32'h0000_0000);
        wr_reg(ADDR_CTRL, 8'h20);
        settle(1);
        check({31'h0, osc_out.bias_double_enable}, 32'h0000_0001);
        @(posedge clock);
        amp_detect <= 1'b1;
        settle(3);
        // a write of zero must not clear the read-only amplitude flag
        wr_reg(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_CTRL, 32'h0000_0010);
        @(posedge clock);
        amp_detect <= 1'b0;
        settle(3);
        rd_chk(ADDR_CTRL, 32'h0000_0000);
    endtask

    task automatic t_load_direct;
        wr_reg(ADDR_LOAD, 8'h7a);
        settle(2);
        check({28'h0, osc_out.cap_applied}, 32'h0000_000a);
        check({31'h0, osc_out.cap_ready}, 32'h0000_0001);
        rd_chk(ADDR_LOAD, 32'h0000_004a);
    endtask

    // steps from 0xa down to 0x3: seven steps, STEP_CYCLES apart
    task automatic t_load_step;
        logic [3:0] prev;
        int steps;
        int last;
        int i;
        steps = 0;
        last = 0;
        wr_reg(ADDR_LOAD, 8'h83);
        settle(2);
        check({31'h0, osc_out.cap_ready}, 32'h0000_0000);
        rd_chk(ADDR_LOAD, 32'h0000_0083);
        // the free-running tick may already have taken the first step, so count from 0xa
        prev = 4'ha;
        for (i = 0; i < 1800 && osc_out.cap_ready !== 1'b1; i++) begin
            settle(1);
            if (osc_out.cap_applied !== prev) begin
                check({28'h0, prev - osc_out.cap_applied}, 32'h0000_0001);
                if (steps > 0) check(i - last, STEP_CYCLES);
                prev = osc_out.cap_applied;
                last = i;
                steps++;
            end
        end
        check(steps, 32'h0000_0007);
        check({28'h0, osc_out.cap_applied}, 32'h0000_0003);
        rd_chk(ADDR_LOAD, 32'h0000_00c3);
        wr_reg(ADDR_LOAD, 8'h0c);
        settle(2);
        check({28'h0, osc_out.cap_applied}, 32'h0000_000c);
        rd_chk(ADDR_LOAD, 32'h0000_004c);
    endtask

    task automatic t_pin_short;
        logic [7:0] codes [6] = '{8'he7, 8'h12, 8'h67, 8'he6, 8'he7, 8'h66};
        logic exp_short [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
        for (int k = 0; k < 6; k++) begin
            wr_reg(ADDR_PIN, codes[k]);
            settle(1);
            check({31'h0, osc_out.crystal_short}, {31'h0, exp_short[k]});
        end
        rd_chk(ADDR_PIN, 32'h0000_0000);
        wr_reg(ADDR_PIN, 8'h67);
        settle(1);
        check({31'h0, osc_out.crystal_short}, 32'h0000_0000);
    endtask

    task automatic t_unmapped;
        logic [31:0] rd;
        logic err;
        wr_reg(ADDR_CTRL, 8'hc0);
        apb_xfer(1'b1, 8'h10, 32'h0000_00ff, rd, err);
        check({31'h0, err}, 32'h0000_0001);
        apb_xfer(1'b0, 8'h20, 32'h0000_0000, rd, err);
        check({31'h0, err}, 32'h0000_0001);
        check(rd, 32'h0000_0000);
        rd_chk(ADDR_CTRL, 32'h0000_00c0);
    endtask

    // ****************************************
    // run control
    // ****************************************
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #(5 * 20000);
        n_errors++;
        stop_test();
    end

    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        req = '0;
        amp_detect = 1'b0;
        n_errors = 0;
        checks_done = 0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset_values();
        t_control();
        t_load_direct();
        t_load_step();
        t_pin_short();
        t_unmapped();
        settle(2);
        stop_test();
    end
endmodule // tb_roc_osc_regs
